// file: verilog/sscmd_map.svh
`ifndef SSCMD_MAP_SVH
`define SSCMD_MAP_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define SSCMD_RESET_COMMAND      8'h01
`define SSCMD_ACTIVITY_INDICATOR 8'h02
`define SSCMD_POWER_DOWN_CONTROL 8'h05
`define SSCMD_OUTPUT_FREQUENCY   8'h10
`define SSCMD_OUTPUT_LEVEL       8'h11
`define SSCMD_TUNING_MODE        8'h12
`define SSCMD_LEVEL_LOOP_MODE    8'h13
`define SSCMD_LEVEL_CONV_WORD    8'h14
`define SSCMD_REFERENCE_CONTROL  8'h15
`define SSCMD_OSC_TRIM_WORD      8'h16
`define SSCMD_STATUS_QUERY       8'h17
`define SSCMD_TEMPERATURE_QUERY  8'h18
`define SSCMD_CAL_MEMORY_READ    8'h20
`define SSCMD_USER_MEMORY_READ   8'h22
`define SSCMD_USER_MEMORY_WRITE  8'h23
`define SSCMD_OUTPUT_ENABLE      8'h26
`define SSCMD_SAVE_DEFAULT_STATE 8'h28
`define SSCMD_LEVEL_TRACK_OFF    8'h29
`define SSCMD_LEVEL_CONV_QUERY   8'h2a
// ----------------------------------------
// payload lengths and field positions
// ----------------------------------------
`define SSCMD_LEN_FREQ           3'h5
`define SSCMD_LEN_WORD           3'h2
`define SSCMD_LEN_TRIPLE         3'h3
`define SSCMD_LEN_BYTE           3'h1
`define SSCMD_LEN_NONE           3'h0
`define SSCMD_FAST_TUNE_BIT      2
`define SSCMD_REF_BACKPLANE_BIT  3
`define SSCMD_REF_HIGH_OUT_BIT   2
`define SSCMD_REF_OUT_BIT        1
`define SSCMD_REF_LOCK_BIT       0
`define SSCMD_MEM_ADDR_MASK      16'h7fff
// ----------------------------------------
// defaults
// ----------------------------------------
`define SSCMD_DEF_FREQUENCY      40'h0000000000
`define SSCMD_DEF_LEVEL          16'h0000
`define SSCMD_DEF_TUNING         3'h0
`define SSCMD_DEF_REFERENCE      4'h0
`define SSCMD_DEF_LEVEL_WORD     14'h0000
`endif

// file: verilog/sscmd_pkg.sv
package sscmd_pkg;
  // programmable device state
  typedef struct packed {
    logic [39:0] frequency;
    logic [15:0] level;
    logic [2:0]  tuning;
    logic        loop_open;
    logic [13:0] level_word;
    logic [3:0]  reference;
    logic        rf_on;
    logic        tracking_off;
  } sscmd_cfg_type;

  // analog status inputs
  typedef struct packed {
    logic ref_osc_lock;
    logic high_ref_lock;
    logic main_lock;
    logic fine_lock;
    logic coarse_lock;
    logic ext_ref_found;
  } sscmd_lock_type;

  typedef enum logic [1:0] {
    SSCMD_IDLE    = 2'b00,
    SSCMD_PAYLOAD = 2'b01,
    SSCMD_EXECUTE = 2'b11
  } sscmd_state_type;
endpackage : sscmd_pkg

// file: verilog/sscmd_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sscmd_map.svh"
// Contract
// - reset command 0x00 restores saved defaults, 0x01 keeps current settings
// - indicator command lights or darkens activity indicator from payload bit 0
// - power-down 1 disables analog section, 0 re-enables with last state
// - frequency command takes 40-bit word, one hertz per bit
// - level command: 15-bit magnitude, bit 15 marks negative
// - tuning bit 2 enables fast tuning, off after reset
// - tuning bits 1:0 select 1 MHz, 25 kHz or 1 Hz steps
// - level-loop payload 0 closed loop, 1 open loop
// - level converter command loads 14-bit word
// - reference bit 3 backplane clock, bit 2 selects 100 MHz output
// - reference bit 1 output enable, bit 0 external lock enable
// - trim loaded from memory at power-up, command 0x16 overrides
// - user write: low byte data, upper two bytes address
// - output enable command follows payload bit 0
// - save command stores configuration as default, payload ignored
// - tracking-off command bit 0 disables automatic level tracking
// - query is command write then read of one to three bytes
// - status query returns status word in three bytes
// - status 15,14,13 report oscillator and main loop locks
// - status 10 fine, 9 coarse lock; 12,11,8 reserved zero
// - status 7 external ref, 6 ref out, 5 ext lock, 4 loop mode
// - status 3 fast tune, 2 power-down, 1 rf output, 0 backplane
// - memory read address top bit ignored, wraps above 0x7fff
// - temperature returns 14 bits, bit 13 sign
module sscmd_top (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_rx_valid,
  input  wire logic [7:0]             i_rx_byte,
  input  wire logic                   i_rx_start,
  input  wire logic                   i_tx_take,
  input  wire sscmd_pkg::sscmd_lock_type i_lock,
  input  wire logic [13:0]            i_temperature,
  input  wire logic [13:0]            i_trim_factory,
  input  wire logic [7:0]             i_cal_data,
  input  wire logic [7:0]             i_user_data,
  output logic                        o_tx_valid,
  output logic [7:0]                  o_tx_byte,
  output logic [2:0]                  o_tx_count,
  output sscmd_pkg::sscmd_cfg_type    o_cfg,
  output logic [13:0]                 o_trim,
  output logic                        o_indicator,
  output logic                        o_power_down,
  output logic                        o_soft_reset,
  output logic [14:0]                 o_mem_addr,
  output logic                        o_user_wr,
  output logic [7:0]                  o_user_wr_data
);
  // ----------------------------------------
  // command framing
  // ----------------------------------------
  sscmd_pkg::sscmd_state_type state_q;
  logic [7:0]  cmd_q;
  logic [39:0] data_q;
  logic [2:0]  left_q;
  logic [2:0]  need;
  logic [7:0]  rx_cmd;

  // payload length per command; unknown codes take one byte
  always_comb begin
    rx_cmd = i_rx_byte;
    case (rx_cmd)
      `SSCMD_OUTPUT_FREQUENCY:  need = `SSCMD_LEN_FREQ;
      `SSCMD_OUTPUT_LEVEL,
      `SSCMD_LEVEL_CONV_WORD,
      `SSCMD_OSC_TRIM_WORD,
      `SSCMD_CAL_MEMORY_READ,
      `SSCMD_USER_MEMORY_READ:  need = `SSCMD_LEN_WORD;
      `SSCMD_USER_MEMORY_WRITE: need = `SSCMD_LEN_TRIPLE;
      `SSCMD_STATUS_QUERY,
      `SSCMD_TEMPERATURE_QUERY,
      `SSCMD_LEVEL_CONV_QUERY:  need = `SSCMD_LEN_NONE;
      default:                  need = `SSCMD_LEN_BYTE;
    endcase
  end

  // command byte first, then payload shifted in msb first
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= sscmd_pkg::SSCMD_IDLE;
      cmd_q   <= 8'h00;
      data_q  <= 40'h0000000000;
      left_q  <= 3'h0;
    end else begin
      case (state_q)
        sscmd_pkg::SSCMD_IDLE: begin
          if (i_rx_valid && i_rx_start) begin
            cmd_q  <= i_rx_byte;
            data_q <= 40'h0000000000;
            left_q <= need;
            state_q <= (need == 3'h0) ? sscmd_pkg::SSCMD_EXECUTE
                                      : sscmd_pkg::SSCMD_PAYLOAD;
          end
        end
        sscmd_pkg::SSCMD_PAYLOAD: begin
          if (i_rx_valid && i_rx_start) begin
            cmd_q  <= i_rx_byte;  // new frame restarts
            data_q <= 40'h0000000000;
            left_q <= need;
            state_q <= (need == 3'h0) ? sscmd_pkg::SSCMD_EXECUTE
                                      : sscmd_pkg::SSCMD_PAYLOAD;
          end else if (i_rx_valid) begin
            data_q <= {data_q[31:0], i_rx_byte};
            left_q <= left_q - 3'h1;
            if (left_q == 3'h1) begin
              state_q <= sscmd_pkg::SSCMD_EXECUTE;
            end
          end
        end
        default: begin
          state_q <= sscmd_pkg::SSCMD_IDLE;
        end
      endcase
    end
  end

  logic exec;
  assign exec = (state_q == sscmd_pkg::SSCMD_EXECUTE);

  // ----------------------------------------
  // configuration state
  // ----------------------------------------
  sscmd_pkg::sscmd_cfg_type cfg_q;
  sscmd_pkg::sscmd_cfg_type saved_q;
  sscmd_pkg::sscmd_cfg_type def_cfg;
  logic        indicator_q;
  logic        power_down_q;
  logic        soft_reset_q;
  logic [13:0] trim_q;
  logic        trim_loaded_q;

  assign def_cfg = '{frequency: `SSCMD_DEF_FREQUENCY, level: `SSCMD_DEF_LEVEL,
                     tuning: `SSCMD_DEF_TUNING, loop_open: 1'b0,
                     level_word: `SSCMD_DEF_LEVEL_WORD,
                     reference: `SSCMD_DEF_REFERENCE, rf_on: 1'b0,
                     tracking_off: 1'b0};

  // command execution; unknown codes fall through untouched
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_q   <= def_cfg;
      saved_q <= def_cfg;
    end else if (exec) begin
      case (cmd_q)
        `SSCMD_RESET_COMMAND: begin
          if (data_q[0] == 1'b0) begin
            cfg_q <= saved_q;
          end
        end
        `SSCMD_OUTPUT_FREQUENCY: cfg_q.frequency  <= data_q;
        `SSCMD_OUTPUT_LEVEL:     cfg_q.level      <= data_q[15:0];
        `SSCMD_TUNING_MODE:      cfg_q.tuning     <= data_q[2:0];
        `SSCMD_LEVEL_LOOP_MODE:  cfg_q.loop_open  <= data_q[0];
        `SSCMD_LEVEL_CONV_WORD:  cfg_q.level_word <= data_q[13:0];
        `SSCMD_REFERENCE_CONTROL: cfg_q.reference <= data_q[3:0];
        `SSCMD_OUTPUT_ENABLE:    cfg_q.rf_on      <= data_q[0];
        `SSCMD_LEVEL_TRACK_OFF:  cfg_q.tracking_off <= data_q[0];
        `SSCMD_SAVE_DEFAULT_STATE: saved_q <= cfg_q;
        default: begin
        end
      endcase
    end
  end

  // indicator and power-down; power-down keeps cfg so re-enable restores it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      indicator_q  <= 1'b0;
      power_down_q <= 1'b0;
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= exec && (cmd_q == `SSCMD_RESET_COMMAND);
      if (exec && cmd_q == `SSCMD_ACTIVITY_INDICATOR) begin
        indicator_q <= data_q[0];
      end
      if (exec && cmd_q == `SSCMD_POWER_DOWN_CONTROL) begin
        power_down_q <= data_q[0];
      end
    end
  end

  // trim: factory value once after reset, then host override
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      trim_q        <= 14'h0000;
      trim_loaded_q <= 1'b0;
    end else if (exec && cmd_q == `SSCMD_OSC_TRIM_WORD) begin
      trim_q        <= data_q[13:0];
      trim_loaded_q <= 1'b1;
    end else if (!trim_loaded_q) begin
      trim_q        <= i_trim_factory;
      trim_loaded_q <= 1'b1;
    end
  end

  // user memory write strobe and shared memory address
  logic [14:0] mem_addr_q;
  logic        user_wr_q;
  logic [7:0]  user_wr_data_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mem_addr_q     <= 15'h0000;
      user_wr_q      <= 1'b0;
      user_wr_data_q <= 8'h00;
    end else begin
      user_wr_q <= exec && (cmd_q == `SSCMD_USER_MEMORY_WRITE);
      if (exec && cmd_q == `SSCMD_USER_MEMORY_WRITE) begin
        mem_addr_q     <= data_q[22:8];
        user_wr_data_q <= data_q[7:0];
      end else if (exec && (cmd_q == `SSCMD_CAL_MEMORY_READ || cmd_q == `SSCMD_USER_MEMORY_READ)) begin
        mem_addr_q <= data_q[14:0];
      end
    end
  end

  // ----------------------------------------
  // query answer
  // ----------------------------------------
  logic [15:0] status;
  logic [23:0] ans_q;
  logic [2:0]  ans_cnt_q;
  logic [2:0]  ans_left_q;
  logic        ans_user_q;
  logic        ans_mem_q;
  logic        mem_pend_q;

  // status word; reserved bits read zero
  assign status = {i_lock.ref_osc_lock, i_lock.high_ref_lock, i_lock.main_lock,
                   2'b00, i_lock.fine_lock, i_lock.coarse_lock, 1'b0,
                   i_lock.ext_ref_found, cfg_q.reference[`SSCMD_REF_OUT_BIT],
                   cfg_q.reference[`SSCMD_REF_LOCK_BIT], cfg_q.loop_open,
                   cfg_q.tuning[`SSCMD_FAST_TUNE_BIT], power_down_q,
                   cfg_q.rf_on, cfg_q.reference[`SSCMD_REF_BACKPLANE_BIT]};

  // memory data is sampled two cycles after the address settles
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ans_q      <= 24'h000000;
      ans_cnt_q  <= 3'h0;
      ans_left_q <= 3'h0;
      ans_mem_q  <= 1'b0;
      ans_user_q <= 1'b0;
      mem_pend_q <= 1'b0;
    end else begin
      mem_pend_q <= 1'b0;
      if (exec && cmd_q == `SSCMD_STATUS_QUERY) begin
        ans_q      <= {8'h00, status};
        ans_cnt_q  <= `SSCMD_LEN_TRIPLE;
        ans_left_q <= `SSCMD_LEN_TRIPLE;
      end else if (exec && cmd_q == `SSCMD_TEMPERATURE_QUERY) begin
        ans_q      <= {10'h000, i_temperature};
        ans_cnt_q  <= `SSCMD_LEN_WORD;
        ans_left_q <= `SSCMD_LEN_WORD;
      end else if (exec && cmd_q == `SSCMD_LEVEL_CONV_QUERY) begin
        ans_q      <= {10'h000, cfg_q.level_word};
        ans_cnt_q  <= `SSCMD_LEN_WORD;
        ans_left_q <= `SSCMD_LEN_WORD;
      end else if (exec && (cmd_q == `SSCMD_CAL_MEMORY_READ || cmd_q == `SSCMD_USER_MEMORY_READ)) begin
        ans_user_q <= (cmd_q == `SSCMD_USER_MEMORY_READ);
        ans_mem_q  <= 1'b1;
        ans_left_q <= 3'h0;  // hold answer until data is captured
      end else if (ans_mem_q) begin
        ans_mem_q  <= 1'b0;
        mem_pend_q <= 1'b1;
      end else if (mem_pend_q) begin
        ans_q      <= {16'h0000, ans_user_q ? i_user_data : i_cal_data};
        ans_cnt_q  <= `SSCMD_LEN_BYTE;
        ans_left_q <= `SSCMD_LEN_BYTE;
      end else if (i_tx_take && ans_left_q != 3'h0) begin
        ans_left_q <= ans_left_q - 3'h1;
      end
    end
  end

  // answer bytes go out msb first
  always_comb begin
    case (ans_left_q)
      3'h3:    o_tx_byte = ans_q[23:16];
      3'h2:    o_tx_byte = ans_q[15:8];
      default: o_tx_byte = ans_q[7:0];
    endcase
  end

  assign o_tx_valid     = (ans_left_q != 3'h0);
  assign o_tx_count     = ans_cnt_q;
  assign o_cfg          = cfg_q;
  assign o_trim         = trim_q;
  assign o_indicator    = indicator_q;
  assign o_power_down   = power_down_q;
  assign o_soft_reset   = soft_reset_q;
  assign o_mem_addr     = mem_addr_q;
  assign o_user_wr      = user_wr_q;
  assign o_user_wr_data = user_wr_data_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_freq_load;
    @(posedge i_clk) disable iff (i_rst)
      (exec && cmd_q == `SSCMD_OUTPUT_FREQUENCY) |=> (o_cfg.frequency == $past(data_q));
  endproperty
  a_freq_load: assert property (p_freq_load) else $error("frequency not loaded");

  property p_power_down;
    @(posedge i_clk) disable iff (i_rst)
      (exec && cmd_q == `SSCMD_POWER_DOWN_CONTROL) |=> (o_power_down == $past(data_q[0]));
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down wrong");

  property p_indicator;
    @(posedge i_clk) disable iff (i_rst)
      (exec && cmd_q == `SSCMD_ACTIVITY_INDICATOR) |=> (o_indicator == $past(data_q[0]));
  endproperty
  a_indicator: assert property (p_indicator) else $error("indicator wrong");

  property p_save_keep;
    @(posedge i_clk) disable iff (i_rst)
      (exec && cmd_q == `SSCMD_RESET_COMMAND && data_q[0]) |=> $stable(o_cfg);
  endproperty
  a_save_keep: assert property (p_save_keep) else $error("reset 0x01 changed state");

  property p_status_bits;
    @(posedge i_clk) disable iff (i_rst)
      (status[12] == 1'b0) && (status[11] == 1'b0) && (status[8] == 1'b0)
      && (status[2] == o_power_down) && (status[1] == o_cfg.rf_on);
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status layout wrong");

  property p_status_answer;
    @(posedge i_clk) disable iff (i_rst)
      (exec && cmd_q == `SSCMD_STATUS_QUERY) |=> (o_tx_valid && o_tx_count == 3'h3);
  endproperty
  a_status_answer: assert property (p_status_answer) else $error("status answer missing");

  property p_user_write;
    @(posedge i_clk) disable iff (i_rst)
      (exec && cmd_q == `SSCMD_USER_MEMORY_WRITE) |=> (o_user_wr && o_user_wr_data == $past(data_q[7:0]));
  endproperty
  a_user_write: assert property (p_user_write) else $error("user write wrong");

  property p_tracking;
    @(posedge i_clk) disable iff (i_rst)
      (exec && cmd_q == `SSCMD_LEVEL_TRACK_OFF) |=> (o_cfg.tracking_off == $past(data_q[0]));
  endproperty
  a_tracking: assert property (p_tracking) else $error("tracking flag wrong");

  property p_mem_answer;
    @(posedge i_clk) disable iff (i_rst)
      (exec && cmd_q == `SSCMD_CAL_MEMORY_READ) |-> ##3 (o_tx_valid && o_tx_count == 3'h1);
  endproperty
  a_mem_answer: assert property (p_mem_answer) else $error("memory answer late");
endmodule : sscmd_top
`default_nettype wire

// file: bench/sscmd_host.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// host side model: frames commands, pulls answers
// ----
module sscmd_host (
  input  wire logic       i_clk,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_byte,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_byte,
  output logic            o_rx_start,
  output logic            o_tx_take
);
  // idle lines at time zero
  initial begin
    o_rx_valid = 1'b0;
    o_rx_byte  = 8'h00;
    o_rx_start = 1'b0;
    o_tx_take  = 1'b0;
  end

  // one byte held across exactly one sampling edge
  task automatic put_byte(input logic [7:0] b, input logic first);
    o_rx_valid = 1'b1;
    o_rx_byte  = b;
    o_rx_start = first;
    @(posedge i_clk);
    #1;
  endtask : put_byte

  // command byte first, payload msb first
  task automatic send(input logic [7:0] cmd, input logic [39:0] data, input int n);
    put_byte(cmd, 1'b1);
    for (int k = n - 1; k >= 0; k--) begin
      put_byte(data[8*k +: 8], 1'b0);
    end
    o_rx_valid = 1'b0;
    o_rx_start = 1'b0;
    o_rx_byte  = ~o_rx_byte; // released data must not look stable
  endtask : send

  // read transfer after the query write, bounded wait for the answer
  task automatic fetch(input int n, output logic [23:0] data, output logic ok);
    int w;
    data = 24'h000000;
    ok   = 1'b1;
    w    = 0;
    while (i_tx_valid !== 1'b1 && w < 16) begin
      @(posedge i_clk);
      #1;
      w++;
    end
    for (int k = 0; k < n; k++) begin
      if (i_tx_valid !== 1'b1) ok = 1'b0;
      data      = {data[15:0], i_tx_byte};
      o_tx_take = 1'b1;
      @(posedge i_clk);
      #1;
    end
    o_tx_take = 1'b0;
  endtask : fetch
endmodule : sscmd_host
`default_nettype wire

// file: bench/signal_source_command_set_tb.sv
`timescale 1ns/1ns
`default_nettype none
module signal_source_command_set_tb;
  typedef struct packed {
    logic [7:0]  cmd;
    logic [2:0]  n;
    logic [39:0] data;
    logic [39:0] exp;
  } sscmd_row_type;

  logic                      clk, rst, rx_valid, rx_start, tx_take, tx_valid;
  logic                      ind, pd, srst, uwr, ok;
  logic [7:0]                rx_byte, tx_byte, cal_d, usr_d, uwd, wr_d;
  logic [2:0]                tx_cnt;
  logic [13:0]               temp, trim_f, trim;
  logic [14:0]               maddr, wr_a;
  logic [23:0]               got;
  sscmd_pkg::sscmd_lock_type lock;
  sscmd_pkg::sscmd_cfg_type  cfg;
  int                        n_fail, n_checks, cycles, wr_n, sr_n;

  sscmd_row_type rows [0:20] = '{
    '{8'h10, 3'h5, 40'h123456789a, 40'h123456789a}, '{8'h11, 3'h2, 40'h83ed, 40'h83ed},
    '{8'h11, 3'h2, 40'h03ed, 40'h03ed}, '{8'h12, 3'h1, 40'h06, 40'h6}, '{8'h12, 3'h1, 40'h01, 40'h1},
    '{8'h12, 3'h1, 40'hf8, 40'h0}, '{8'h12, 3'h1, 40'h02, 40'h2}, '{8'h13, 3'h1, 40'h01, 40'h1},
    '{8'h13, 3'h1, 40'h00, 40'h0}, '{8'h14, 3'h2, 40'hffff, 40'h3fff}, '{8'h14, 3'h2, 40'h0155, 40'h155},
    '{8'h15, 3'h1, 40'h0f, 40'hf}, '{8'h15, 3'h1, 40'hf4, 40'h4}, '{8'h16, 3'h2, 40'h1234, 40'h1234},
    '{8'h26, 3'h1, 40'h01, 40'h1}, '{8'h26, 3'h1, 40'hfe, 40'h0}, '{8'h29, 3'h1, 40'h01, 40'h1},
    '{8'h02, 3'h1, 40'h01, 40'h1}, '{8'h02, 3'h1, 40'h00, 40'h0}, '{8'h05, 3'h1, 40'h01, 40'h1},
    '{8'h05, 3'h1, 40'h00, 40'h0}};

  // behavioural memories answer from the address
  assign cal_d = maddr[7:0] ^ 8'h3c;
  assign usr_d = ~maddr[7:0];

  sscmd_top sscmd_top_inst (
    .i_clk(clk), .i_rst(rst), .i_rx_valid(rx_valid), .i_rx_byte(rx_byte), .i_rx_start(rx_start),
    .i_tx_take(tx_take), .i_lock(lock), .i_temperature(temp), .i_trim_factory(trim_f),
    .i_cal_data(cal_d), .i_user_data(usr_d), .o_tx_valid(tx_valid), .o_tx_byte(tx_byte),
    .o_tx_count(tx_cnt), .o_cfg(cfg), .o_trim(trim), .o_indicator(ind), .o_power_down(pd),
    .o_soft_reset(srst), .o_mem_addr(maddr), .o_user_wr(uwr), .o_user_wr_data(uwd));

  sscmd_host sscmd_host_inst (
    .i_clk(clk), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte), .o_rx_valid(rx_valid),
    .o_rx_byte(rx_byte), .o_rx_start(rx_start), .o_tx_take(tx_take));

  // ----
  // clock, pulse monitors, hang guard
  // ----
  always #2 clk = ~clk;

  // pulses last one cycle, so count them at the edge
  always @(posedge clk) begin
    cycles++;
    if (uwr === 1'b1) begin
      wr_n++;
      wr_a = maddr;
      wr_d = uwd;
    end
    if (srst === 1'b1) sr_n++;
    if (cycles >= 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ----
  // helpers
  // ----
  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // config lands one edge after the edge that takes the last byte; three leaves margin
  task automatic cmd(input logic [7:0] c, input logic [39:0] d, input int n);
    sscmd_host_inst.send(c, d, n);
    repeat (3) @(posedge clk);
    #1;
  endtask : cmd

  task automatic query(input logic [7:0] c, input logic [39:0] d, input int n, input int nb);
    sscmd_host_inst.send(c, d, n);
    // let a new query replace any pending answer before pulling bytes
    repeat (2) @(posedge clk);
    #1;
    sscmd_host_inst.fetch(nb, got, ok);
    check("answer ready", 40'(ok), 40'h1);
    check("answer count", 40'(tx_cnt), 40'(nb));
    check("answer drained", 40'(tx_valid), 40'h0);
  endtask : query

  function automatic logic [39:0] pick(input logic [7:0] c);
    case (c)
      8'h02: return 40'(ind);
      8'h05: return 40'(pd);
      8'h10: return cfg.frequency;
      8'h11: return 40'(cfg.level);
      8'h12: return 40'(cfg.tuning);
      8'h13: return 40'(cfg.loop_open);
      8'h14: return 40'(cfg.level_word);
      8'h15: return 40'(cfg.reference);
      8'h16: return 40'(trim);
      8'h26: return 40'(cfg.rf_on);
      default: return 40'(cfg.tracking_off);
    endcase
  endfunction : pick

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // ----
  // main sequence
  // ----
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    lock = 6'b101101;
    temp = 14'h2abc;
    trim_f = 14'h1abc;
    {n_fail, n_checks, cycles, wr_n, sr_n} = '0;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("cfg after reset", 40'(cfg.tuning), 40'h0);
    check("factory trim", 40'(trim), 40'(trim_f));
    $display("test reset done");
    foreach (rows[i]) begin
      cmd(rows[i].cmd, rows[i].data, int'(rows[i].n));
      check("row output", pick(rows[i].cmd), rows[i].exp);
    end
    $display("test table done");
    cmd(8'h12, 40'h04, 1);
    cmd(8'h13, 40'h01, 1);
    cmd(8'h15, 40'h0a, 1);
    query(8'h17, 40'h0, 0, 3);
    check("status", 40'(got), 40'h00a4d9);
    cmd(8'h05, 40'h01, 1);
    cmd(8'h26, 40'h01, 1);
    query(8'h17, 40'h0, 0, 3);
    check("status down", 40'(got), 40'h00a4df);
    $display("test status done");
    query(8'h18, 40'h0, 0, 2);
    check("temperature", 40'(got), 40'h2abc);
    sscmd_host_inst.send(8'h17, 40'h0, 0);
    // a start byte in the execute cycle is dropped, so leave one edge
    @(posedge clk);
    #1;
    query(8'h2a, 40'h0, 0, 2);
    check("level word query", 40'(got), 40'h0155);
    query(8'h20, 40'h8005, 2, 1);
    check("cal addr", 40'(maddr), 40'h0005);
    check("cal data", 40'(got), 40'h39);
    query(8'h22, 40'h1234, 2, 1);
    check("user data", 40'(got), 40'hcb);
    cmd(8'h23, 40'h1f0022, 3);
    check("user write", {wr_n[7:0], 9'h0, wr_a, wr_d}, {8'h1, 9'h0, 15'h1f00, 8'h22});
    $display("test memory done");
    sscmd_host_inst.send(8'h10, 40'hffff, 2);
    // idle edge between frames; the cut frame still waits for payload
    @(posedge clk);
    #1;
    cmd(8'h26, 40'h00, 1);
    cmd(8'h77, 40'hff, 1);
    check("aborted frame", cfg.frequency, 40'h123456789a);
    check("after abort", 40'(cfg.rf_on), 40'h0);
    cmd(8'h28, 40'h55, 1);
    cmd(8'h12, 40'h01, 1);
    cmd(8'h10, 40'h0abc, 5);
    cmd(8'h01, 40'h01, 1);
    check("keep state", cfg.frequency, 40'h0abc);
    cmd(8'h01, 40'h00, 1);
    check("saved freq", cfg.frequency, 40'h123456789a);
    check("saved tuning", 40'(cfg.tuning), 40'h4);
    check("soft resets", 40'(sr_n), 40'h2);
    $display("test save and reset done");
    report_and_stop();
  end
endmodule : signal_source_command_set_tb
`default_nettype wire
